/* rtl/acc_top.sv */
// Successive-approximation converter sequencer with register file
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/10ps

// Summary of operation
// - Converter runs only while converter_on set.
// - idle_stop halts converter during device idle.
// - output_format selects four result justifications.
// - Code 111: sample counter ends sampling.
// - Code 110: charge unit event ends sampling.
// - Code 010: timer three match ends sampling.
// - Code 001: external interrupt edge ends sampling.
// - Code 000: software clears sample_enable, converts.
// - auto_sample_start restarts sampling after conversion.
// - Otherwise software sets sample_enable to sample.
// - sample_enable reads one while acquiring.
// - Done bit set by hardware, writable.
// - Result buffer cleared when converter turned off.
// - Result buffer holds sixteen words.
// - Ten-bit successive approximation per conversion.
// - Unimplemented control bits read as zero.
module acc_top
    import acc_pkg::*;
(
    input  wire logic        sys_clk,        // System clock
    input  wire logic        resetn,         // Async reset, active low
    input  wire logic [4:0]  reg_addr,       // Register index
    input  wire logic [15:0] reg_wdata,      // Write data
    input  wire logic        reg_wr,         // Write strobe
    input  wire logic        reg_rd,         // Read strobe
    output logic      [15:0] reg_rdata,      // Read data, cycle after strobe
    input  wire logic        device_idle,    // Device in idle state
    input  wire logic        charge_event,   // Charge time unit event
    input  wire logic        timer_three,    // Timer three compare match
    input  wire logic        ext_int_pin,    // External interrupt zero pin
    input  wire logic        cmp_high,       // Comparator: input at or above trial
    output logic             sample_hold,    // High: sample/hold acquiring
    output logic [9:0]       dac_trial,      // Trial code to comparator
    output logic             irq             // Level interrupt
);

    // Sequencer walks off, idle, sampling and converting
    // Off is forced whenever converter_on is clear
    // Idle waits for software to set the sample bit
    // Sampling holds until the chosen trigger fires
    // Converting takes one clock per result bit
    // All four codes are legal, so no default arm
    // Converter states
    typedef enum logic [1:0]
    {
        ACC_ST_OFF  = 2'b00,
        ACC_ST_IDLE = 2'b01,
        ACC_ST_SAMPLE_ENABLE = 2'b10,
        ACC_ST_CONV = 2'b11
    } acc_state_type;

    // Four justifications of the ten-bit result
    // Fractional forms put the result in the top bits
    // Integer forms keep it in the bottom bits
    // Signed integer form copies the result's top bit as sign
    // No offset inversion is applied to the code
    // Output is always a full sixteen-bit word
    // Format a raw code into a buffer word
    function automatic logic [15:0] acc_format(input logic [1:0] fmt, input logic [9:0] d);
        logic [15:0] w;
        w = 16'h0000;
        unique case (fmt)
            ACC_FMT_SFRAC: w = {d, 6'h00};
            ACC_FMT_FRAC:  w = {d, 6'h00};
            ACC_FMT_SINT:  w = {{6{d[9]}}, d};
            ACC_FMT_INT:   w = {6'h00, d};
        endcase
        return w;
    endfunction : acc_format

    acc_state_type state_reg;            // Sequencer state
    acc_state_type state_next;           // Next state
    logic [15:0]   ctrl_reg;             // Control register storage
    logic [15:0]   ctrl_next;            // Next control value
    logic [15:0]   buf_mem [0:15];       // Result buffer
    logic [3:0]    wptr_reg;             // Buffer write pointer
    logic [9:0]    sar_reg;              // Approximation register
    logic [3:0]    bit_reg;              // Bit under test
    logic [7:0]    scnt_len_reg;         // Sample counter length
    logic [7:0]    scnt_reg;             // Sample counter
    logic [1:0]    ists_reg;             // Sticky interrupt status
    logic [1:0]    ien_reg;              // Interrupt enable
    logic [2:0]    pin_sync_reg;         // Pin synchroniser
    logic          pin_last_reg;         // Accepted pin level
    logic          sample_enable_d_reg;           // Delayed sample bit

    // Register strobes decode the index only
    // Unmapped indices simply fall through
    // Halt is idle_stop together with device idle
    // Pin edge needs two agreeing late stages
    // Comparator decides the bit under test
    // Wrap flag rides on the sixteenth result
    // Decoded strobes and conditions
    wire        wr_ctrl   = reg_wr && (reg_addr == ACC_CTRL_ADDR);
    wire        wr_clr    = reg_wr && (reg_addr == ACC_CLR_ADDR);
    wire        wr_ien    = reg_wr && (reg_addr == ACC_IEN_ADDR);
    wire        wr_scnt   = reg_wr && (reg_addr == ACC_SCNT_ADDR);
    wire        conv_on   = ctrl_reg[ACC_ON_BIT];
    wire        halted    = ctrl_reg[ACC_SIDL_BIT] && device_idle;
    wire [2:0]  src       = ctrl_reg[ACC_SRC_LSB +: 3];
    wire [1:0]  fmt       = ctrl_reg[ACC_OUTPUT_FORMAT_LSB +: 2];
    wire        sample_enable_bit  = ctrl_reg[ACC_SAMPLE_ENABLE_BIT];
    wire        pin_edge  = (pin_sync_reg[2] == pin_sync_reg[1]) &&
                            (pin_sync_reg[1] != pin_last_reg) && pin_sync_reg[1];
    wire        sar_last  = (bit_reg == 4'h0);
    wire [9:0]  sar_keep  = cmp_high ? sar_reg : (sar_reg & ~(10'h001 << bit_reg));
    wire [9:0]  sar_final = sar_keep;
    wire        conv_end  = (state_reg == ACC_ST_CONV) && !halted && sar_last;
    wire        buf_full  = conv_end && (wptr_reg == 4'hf);

    // One trigger per source code
    // Manual source watches the falling sample bit
    // Counter source fires when the count is spent
    // Timer and charge inputs share this clock
    // Reserved codes never end sampling here
    // Only software clearing the bit can stop them
    // Trigger that ends sampling for each source code
    logic trig;
    always_comb
    begin
        trig = 1'b0;
        unique case (src)
            ACC_SRC_AUTO:   trig = (scnt_reg == 8'h00);
            ACC_SRC_CHARGE: trig = charge_event;
            ACC_SRC_TIMER:  trig = timer_three;
            ACC_SRC_EXTPIN: trig = pin_edge;
            ACC_SRC_MANUAL: trig = sample_enable_d_reg && !sample_enable_bit;
            default:        trig = 1'b0;
        endcase
    end

    // Turning off wins over everything else
    // Halt freezes the current state in place
    // Idle leaves only when the sample bit is set
    // Sampling ends on trigger or cleared bit
    // Conversion end returns to idle or resamples
    // Auto-start decides which of the two
    // Next state of the sequencer
    always_comb
    begin
        state_next = state_reg;
        if (!conv_on)
            state_next = ACC_ST_OFF;
        else if (halted)
            state_next = state_reg;
        else
        begin
            unique case (state_reg)
                ACC_ST_OFF:  state_next = ACC_ST_IDLE;
                ACC_ST_IDLE: if (sample_enable_bit) state_next = ACC_ST_SAMPLE_ENABLE;
                ACC_ST_SAMPLE_ENABLE: if (trig || !sample_enable_bit) state_next = ACC_ST_CONV;
                ACC_ST_CONV: if (sar_last)
                                 state_next = ctrl_reg[ACC_AUTO_SAMPLE_START_BIT] ? ACC_ST_SAMPLE_ENABLE
                                                                     : ACC_ST_IDLE;
            endcase
        end
    end

    // Software write lands first in the cycle
    // Hardware updates then override single bits
    // Unused bits are masked so they read zero
    // Done clears as a conversion begins
    // Done sets and auto-start re-arms at the end
    // Sample bit cannot stay set while off
    // Next control value: software write, then hardware updates
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl)
            ctrl_next = reg_wdata & ACC_CTRL_MASK;
        // Hardware clears sample bit when a trigger ends sampling
        if (state_reg == ACC_ST_SAMPLE_ENABLE && !halted && trig && src != ACC_SRC_MANUAL)
            ctrl_next[ACC_SAMPLE_ENABLE_BIT] = 1'b0;
        // Start of conversion clears done
        if (state_reg == ACC_ST_SAMPLE_ENABLE && state_next == ACC_ST_CONV)
            ctrl_next[ACC_DONE_BIT] = 1'b0;
        if (conv_end)
        begin
            ctrl_next[ACC_DONE_BIT] = 1'b1;
            if (ctrl_reg[ACC_AUTO_SAMPLE_START_BIT])
                ctrl_next[ACC_SAMPLE_ENABLE_BIT] = 1'b1;
        end
        if (!ctrl_next[ACC_ON_BIT])
            ctrl_next[ACC_SAMPLE_ENABLE_BIT] = 1'b0;
    end

    // Everything resets to the all-zero control word
    // Delayed sample bit finds its falling edge
    // Control register and sequencer state
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_reg   <= ACC_CTRL_RESET;
            state_reg  <= ACC_ST_OFF;
            sample_enable_d_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg   <= ctrl_next;
            state_reg  <= state_next;
            sample_enable_d_reg <= sample_enable_bit;
        end
    end

    // Three stages guard against metastability
    // First stage is read only by the second
    // Accepted level updates only on agreement
    // Idle level after reset matches a low pin
    // External pin synchroniser, change accepted when stages agree
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_sync_reg <= 3'h0;
            pin_last_reg <= 1'b0;
        end
        else
        begin
            pin_sync_reg <= {pin_sync_reg[1:0], ext_int_pin};
            if (pin_sync_reg[2] == pin_sync_reg[1])
                pin_last_reg <= pin_sync_reg[1];
        end
    end

    // Length is software programmable
    // Reload happens in every non-sampling cycle
    // Count freezes while halted
    // Zero count is the auto-convert trigger
    // A zero length converts at once
    // Sample counter: reloads on entry to sampling, counts down
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            scnt_len_reg <= ACC_SCNT_RESET;
            scnt_reg     <= ACC_SCNT_RESET;
        end
        else
        begin
            if (wr_scnt)
                scnt_len_reg <= reg_wdata[7:0];
            if (state_reg != ACC_ST_SAMPLE_ENABLE)
                scnt_reg <= scnt_len_reg;
            else if (!halted && scnt_reg != 8'h00)
                scnt_reg <= scnt_reg - 8'h01;
        end
    end

    // Trial starts at mid-scale each conversion
    // Each step keeps or drops the bit under test
    // Next lower bit is then tried
    // Last bit is settled in the end cycle
    // Halt holds the trial code steady
    // Successive approximation, one bit per clock, MSB first
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sar_reg <= 10'h000;
            bit_reg <= 4'h0;
        end
        else if (state_reg != ACC_ST_CONV)
        begin
            sar_reg <= 10'h200;
            bit_reg <= 4'h9;
        end
        else if (!halted && !sar_last)
        begin
            sar_reg <= sar_keep | (10'h001 << (bit_reg - 4'h1));
            bit_reg <= bit_reg - 4'h1;
        end
    end

    // Pointer wraps after sixteen results
    // Turning off rewinds the pointer
    // Software must read results before that
    // Result buffer write; cleared while converter is off
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            wptr_reg <= 4'h0;
        else if (!conv_on)
            wptr_reg <= 4'h0;
        else if (conv_end)
            wptr_reg <= wptr_reg + 4'h1;
    end

    // Sixteen words, no reset needed
    // Contents are wiped while off
    // Formatting is applied on the way in
    // Buffer storage
    always_ff @(posedge sys_clk)
    begin
        for (int i = 0; i < ACC_BUF_DEPTH; i++)
        begin
            if (!conv_on)
                buf_mem[i] <= 16'h0000;
            else if (conv_end && wptr_reg == 4'(i))
                buf_mem[i] <= acc_format(fmt, sar_final);
        end
    end

    // Sticky bits set by hardware events
    // Write-one clear in the same cycle loses
    // Enable register has the same layout
    // Interrupt status: set wins over clear
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ists_reg <= 2'h0;
            ien_reg  <= 2'h0;
        end
        else
        begin
            ists_reg <= (ists_reg & ~(wr_clr ? reg_wdata[1:0] : 2'h0)) |
                        {buf_full, conv_end};
            if (wr_ien)
                ien_reg <= reg_wdata[1:0];
        end
    end

    // Read data is zero outside the answer cycle
    // Upper half of the index selects the buffer
    // Clear register reads back as zero
    // Read data one cycle after the read strobe
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
        begin
            if (reg_addr[4])
                reg_rdata <= buf_mem[reg_addr[3:0]];
            else if (reg_addr == ACC_CTRL_ADDR)
                reg_rdata <= ctrl_reg;
            else if (reg_addr == ACC_STAT_ADDR)
                reg_rdata <= {14'h0000, ists_reg};
            else if (reg_addr == ACC_IEN_ADDR)
                reg_rdata <= {14'h0000, ien_reg};
            else if (reg_addr == ACC_SCNT_ADDR)
                reg_rdata <= {8'h00, scnt_len_reg};
            else
                reg_rdata <= 16'h0000;
        end
        else
            reg_rdata <= 16'h0000;
    end

    // Sample/hold follows the sampling state
    // Trial code goes straight to the comparator
    // Interrupt is a plain level
    // Analog-facing outputs and interrupt
    assign sample_hold = (state_reg == ACC_ST_SAMPLE_ENABLE);
    assign dac_trial   = sar_reg;
    assign irq         = |(ists_reg & ien_reg);

endmodule : acc_top

/* inc/acc_pkg.sv */
// Constants shared by the converter control block
package acc_pkg;
    // Register indices on the plain register port
    localparam logic [4:0] ACC_CTRL_ADDR    = 5'h00;
    localparam logic [4:0] ACC_STAT_ADDR    = 5'h01;
    localparam logic [4:0] ACC_CLR_ADDR     = 5'h02;
    localparam logic [4:0] ACC_IEN_ADDR     = 5'h03;
    localparam logic [4:0] ACC_SCNT_ADDR    = 5'h04;
    localparam logic [4:0] ACC_BUF_BASE     = 5'h10;
    // Control register fields
    localparam int ACC_ON_BIT    = 15;
    localparam int ACC_SIDL_BIT  = 13;
    localparam int ACC_OUTPUT_FORMAT_LSB  = 8;
    localparam int ACC_SRC_LSB   = 5;
    localparam int ACC_AUTO_SAMPLE_START_BIT  = 2;
    localparam int ACC_SAMPLE_ENABLE_BIT  = 1;
    localparam int ACC_DONE_BIT  = 0;
    // Writable bits of the control register
    localparam logic [15:0] ACC_CTRL_MASK  = 16'ha3e7;
    localparam logic [15:0] ACC_CTRL_RESET = 16'h0000;
    // Sample counter default length in clock cycles
    localparam logic [7:0]  ACC_SCNT_RESET = 8'h10;
    // Conversion: one cycle per result bit
    localparam int ACC_RES_BITS = 10;
    localparam int ACC_BUF_DEPTH = 16;
    // Format codes
    typedef enum logic [1:0]
    {
        ACC_FMT_INT   = 2'b00,
        ACC_FMT_SINT  = 2'b01,
        ACC_FMT_FRAC  = 2'b10,
        ACC_FMT_SFRAC = 2'b11
    } acc_fmt_type;
    // Trigger source codes
    localparam logic [2:0] ACC_SRC_MANUAL = 3'b000;
    localparam logic [2:0] ACC_SRC_EXTPIN = 3'b001;
    localparam logic [2:0] ACC_SRC_TIMER  = 3'b010;
    localparam logic [2:0] ACC_SRC_CHARGE = 3'b110;
    localparam logic [2:0] ACC_SRC_AUTO   = 3'b111;
    // Interrupt status bits
    localparam int ACC_EV_DONE = 0;
    localparam int ACC_EV_FULL = 1;
endpackage : acc_pkg

/* sim/acc_analog_model.sv */
// Behavioural sample/hold and comparator facing the sequencer
`timescale 1ns/10ps
module acc_analog_model
(
    input  wire logic       sys_clk,
    input  wire logic       sample_hold,
    input  wire logic [9:0] dac_trial,
    input  wire logic [9:0] analog_in,
    output logic            cmp_high
);
    logic [9:0] held_reg;          // Voltage held on the capacitor
    logic       junk_reg = 1'b0;   // Comparator noise while tracking
    // Track while acquiring, freeze while holding
    always_ff @(posedge sys_clk)
    begin
        junk_reg <= ~junk_reg;
        if (sample_hold)
            held_reg <= analog_in;
    end
    // Input at or above trial code keeps the bit
    assign cmp_high = sample_hold ? junk_reg : (held_reg >= dac_trial);
endmodule : acc_analog_model

/* sim/acc_top_assertions.sv */
// Port-level checks for the converter sequencer
`timescale 1ns/10ps
module acc_checker
    import acc_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic [4:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        device_idle,
    input wire logic        sample_hold,
    input wire logic [9:0]  dac_trial,
    input wire logic        irq
);
    logic       on_reg, idle_reg, auto_sample_start_reg, ien_reg; // Shadowed control bits and interrupt enable
    logic [2:0] src_reg;                             // Shadowed trigger source
    wire        ctrl_wr = reg_wr && reg_addr == ACC_CTRL_ADDR;
    // Follow software writes
    always_ff @(posedge sys_clk or negedge resetn)
        if (!resetn)
            {on_reg, idle_reg, auto_sample_start_reg, src_reg, ien_reg} <= 7'h00;
        else if (ctrl_wr)
            {on_reg, idle_reg, auto_sample_start_reg, src_reg} <=
                {reg_wdata[15], reg_wdata[13], reg_wdata[2], reg_wdata[7:5]};
        else if (reg_wr && reg_addr == ACC_IEN_ADDR)
            ien_reg <= reg_wdata[0];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    property p_unimpl;
        $past(reg_rd) && $past(reg_addr) == ACC_CTRL_ADDR |-> (reg_rdata & 16'h5c18) == 16'h0000;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unused control bit reads high");
    property p_off;
        ctrl_wr && !reg_wdata[15] |-> ##[1:2] !sample_hold;
    endproperty
    a_off: assert property (p_off) else $error("sampling while off");
    property p_start;
        ctrl_wr && reg_wdata[15] && reg_wdata[1] && !(reg_wdata[13] && device_idle)
            |-> ##[1:3] sample_hold;
    endproperty
    a_start: assert property (p_start) else $error("sampling did not start");
    property p_sar;
        $fell(sample_hold) |-> !sample_hold [*8];
    endproperty
    a_sar: assert property (p_sar) else $error("conversion too short");
    property p_done;
        $fell(sample_hold) && on_reg && ien_reg && !idle_reg |-> ##[8:16] irq;
    endproperty
    a_done: assert property (p_done) else $error("no done interrupt");
    property p_auto;
        $fell(sample_hold) && on_reg && auto_sample_start_reg && !idle_reg |-> ##[9:16] sample_hold;
    endproperty
    a_auto: assert property (p_auto) else $error("no automatic resample");
    property p_freeze;
        idle_reg && device_idle && $past(device_idle) && !$past(reg_wr)
            |-> $stable(dac_trial) && $stable(sample_hold);
    endproperty
    a_freeze: assert property (p_freeze) else $error("ran during idle");
    property p_swhold;
        sample_hold && on_reg && !(src_reg inside {3'b001, 3'b010, 3'b110, 3'b111})
            && !reg_wr && !$past(reg_wr) |=> sample_hold;
    endproperty
    a_swhold: assert property (p_swhold) else $error("sampling ended by hardware");
endmodule : acc_checker
bind acc_top acc_checker u_checker
(
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .device_idle(device_idle),
    .sample_hold(sample_hold), .dac_trial(dac_trial), .irq(irq)
);

/* sim/tb_adc_conversion_control.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
module tb_adc_conversion_control;
    import acc_pkg::*;
    typedef struct packed {logic [2:0] src; logic [1:0] fmt; logic [9:0] vin; logic [15:0] exp;}
        acc_row_type;
    // Source, format, input voltage, expected buffer word
    localparam acc_row_type ROWS [5] = '{'{3'b000, 2'b00, 10'h2a5, 16'h02a5},
        '{3'b001, 2'b01, 10'h2a5, 16'hfea5}, '{3'b010, 2'b10, 10'h15a, 16'h5680},
        '{3'b110, 2'b11, 10'h3ff, 16'hffc0}, '{3'b111, 2'b00, 10'h001, 16'h0001}};
    logic        sys_clk = 1'b0, resetn, reg_wr, reg_rd, device_idle, cmp_high, sample_hold, irq;
    logic        charge_event, timer_three, ext_int_pin;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d, c;
    logic [9:0]  dac_trial, analog_in;
    int          errors = 0, comparisons = 0, n;
    always #50 sys_clk = ~sys_clk;
    acc_top uut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .device_idle(device_idle),
        .charge_event(charge_event), .timer_three(timer_three), .ext_int_pin(ext_int_pin),
        .cmp_high(cmp_high), .sample_hold(sample_hold), .dac_trial(dac_trial), .irq(irq));
    acc_analog_model u_model (.sys_clk(sys_clk), .sample_hold(sample_hold),
        .dac_trial(dac_trial), .analog_in(analog_in), .cmp_high(cmp_high));
    task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task chb(input string nm, input logic got, input logic exp);
        chk(nm, {15'h0, got}, {15'h0, exp});
    endtask : chb
    task wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    // Pulse the trigger input of a source code; code 000 clears the sample bit instead, code 111 does nothing
    task fire(input logic [2:0] s, input logic [15:0] v);
        if (s == 3'b000)
            wr(ACC_CTRL_ADDR, v & 16'hfffd);
        else if (s != 3'b111)
        begin
            @(posedge sys_clk);
            {charge_event, timer_three, ext_int_pin} <= {s == 3'b110, s == 3'b010, s == 3'b001};
            repeat (4) @(posedge sys_clk);
            {charge_event, timer_three, ext_int_pin} <= 3'b000;
        end
    endtask : fire
    task wait_irq;
        for (n = 0; n < 60 && irq !== 1'b1; n++)
            @(posedge sys_clk);
        #1 chb("irq", irq, 1'b1);
    endtask : wait_irq
    task conclude;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    initial
    begin
        #2000000 errors++;
        conclude;
    end
    initial
    begin
        {resetn, reg_wr, reg_rd, reg_addr, reg_wdata, device_idle} = '0;
        {charge_event, timer_three, ext_int_pin, analog_in} = '0;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        #1 chk("outputs", {4'h0, dac_trial, sample_hold, irq}, 16'h0000);
        rd(ACC_CTRL_ADDR, d); chk("control", d, 16'h0000);
        rd(ACC_SCNT_ADDR, d); chk("count", d, 16'h0010);
        wr(ACC_CTRL_ADDR, 16'h7ffd);
        rd(ACC_CTRL_ADDR, d); chk("control", d, 16'h23e5);
        wr(ACC_CTRL_ADDR, 16'h0000);
        wr(5'h08, 16'hffff);
        rd(5'h08, d); chk("unmapped", d, 16'h0000);
        wr(ACC_IEN_ADDR, 16'h0001);
        device_idle <= 1'b1;
        foreach (ROWS[i])
        begin
            analog_in <= ROWS[i].vin;
            c = 16'h8002 | {6'h0, ROWS[i].fmt, 8'h00} | {8'h00, ROWS[i].src, 5'h00};
            wr(ACC_CTRL_ADDR, c);
            repeat (4) @(posedge sys_clk);
            #1 chb("sampling", sample_hold, 1'b1);
            fire(ROWS[i].src, c);
            wait_irq;
            chb("sampling", sample_hold, 1'b0);
            rd(ACC_CTRL_ADDR, d); chk("control", d, (c & 16'hfffd) | 16'h0001);
            rd(ACC_BUF_BASE + i[4:0], d); chk("result", d, ROWS[i].exp);
            wr(ACC_IEN_ADDR, 16'h0000); chb("irq", irq, 1'b0);
            rd(ACC_STAT_ADDR, d); chk("status", d, 16'h0001);
            wr(ACC_IEN_ADDR, 16'h0001); chb("irq", irq, 1'b1);
            wr(ACC_CLR_ADDR, 16'h0001); chb("irq", irq, 1'b0);
        end
        wr(ACC_CTRL_ADDR, 16'h8062);
        fire(3'b001, c); fire(3'b010, c); fire(3'b110, c);
        #1 chb("sampling", sample_hold, 1'b1);
        wr(ACC_CTRL_ADDR, 16'h0000); device_idle <= 1'b0;
        rd(ACC_BUF_BASE, d); chk("result", d, 16'h0000);
        wr(ACC_CTRL_ADDR, 16'ha0e2);
        repeat (3) @(posedge sys_clk);
        device_idle <= 1'b1;
        repeat (40) @(posedge sys_clk);
        #1 chb("sampling", sample_hold, 1'b1);
        device_idle <= 1'b0;
        wait_irq;
        wr(ACC_CTRL_ADDR, 16'h0000); wr(ACC_CLR_ADDR, 16'h0003); wr(ACC_IEN_ADDR, 16'h0003);
        wr(ACC_SCNT_ADDR, 16'h0002); analog_in <= 10'h0c3;
        wr(ACC_CTRL_ADDR, 16'h80e6);
        d = 16'h0000;
        for (int k = 0; k < 300 && d[1] !== 1'b1; k++)
            rd(ACC_STAT_ADDR, d);
        chb("wrapped", d[1], 1'b1);
        rd(ACC_BUF_BASE + 5'd15, d); chk("result", d, 16'h00c3);
        wr(ACC_CTRL_ADDR, 16'h0000); wr(ACC_CLR_ADDR, 16'h0003); chb("irq", irq, 1'b0);
        rd(ACC_BUF_BASE + 5'd15, d); chk("result", d, 16'h0000);
        conclude;
    end
endmodule : tb_adc_conversion_control
